// [imtr_pkg.sv]
// Purpose: constants shared by the infrared motion / touch readout block
// Assumes: byte-wide register map, 8-bit addresses
// Notes:   multi-byte values put the high byte at the lower address
package imtr_pkg;
	// register offsets
	localparam logic [7:0] EVENT_FLAGS_ADDR      = 8'h10;
	localparam logic [7:0] GLOBAL_ACT_ADDR       = 8'h12;
	localparam logic [7:0] LIGHTING_FLAGS_ADDR   = 8'h13;
	localparam logic [7:0] RAW_COUNT_HI_ADDR     = 8'h22;
	localparam logic [7:0] RAW_COUNT_LO_ADDR     = 8'h23;
	localparam logic [7:0] POS_SUM_HI_ADDR       = 8'h34;
	localparam logic [7:0] POS_SUM_LO_ADDR       = 8'h35;
	localparam logic [7:0] NEG_SUM_HI_ADDR       = 8'h36;
	localparam logic [7:0] NEG_SUM_LO_ADDR       = 8'h37;
	localparam logic [7:0] CH0_SENSOR_CFG_ADDR   = 8'h50;
	localparam logic [7:0] CH1_SENSOR_CFG_ADDR   = 8'h51;
	localparam logic [7:0] GLOBAL_SENSOR_CFG_ADDR = 8'h53;
	localparam logic [7:0] CH0_TUNING_CFG_ADDR   = 8'h54;
	localparam logic [7:0] CH1_TUNING_CFG_ADDR   = 8'h55;
	localparam logic [7:0] EXTRA_SENSOR_CFG_ADDR = 8'h57;
	localparam logic [7:0] PROXIMITY_LEVEL_ADDR  = 8'h60;
	localparam logic [7:0] CONTACT_LEVEL_ADDR    = 8'h61;
	localparam logic [7:0] MOTION_CFG_ADDR       = 8'h90;
	localparam logic [7:0] MOTION_ENTER_ADDR     = 8'h91;
	localparam logic [7:0] MOTION_EXIT_ADDR      = 8'h92;
	localparam logic [7:0] MOTION_SCALE_ADDR     = 8'h93;

	// field positions
	localparam int CONTACT_EVENT_BIT   = 0;
	localparam int MOTION_TRIGGER_BIT  = 1;
	localparam int NEAR_FLAG_BIT       = 0;
	localparam int CONTACT_FLAG_BIT    = 1;
	localparam int INFRARED_EVENT_BIT  = 3;
	localparam int DUTY_RISING_BIT     = 3;
	localparam int PWM_CHANGING_BIT    = 4;
	localparam int CH0_RX0_ENABLE_BIT  = 0;

	// reset values
	localparam logic [7:0]  CFG_RESET     = 8'h00;
	localparam logic [7:0]  PROX_RESET    = 8'h08;
	localparam logic [7:0]  CONTACT_RESET = 8'h10;
	localparam logic [7:0]  ENTER_RESET   = 8'h10;
	localparam logic [7:0]  EXIT_RESET    = 8'h08;
	localparam logic [7:0]  SCALE_RESET   = 8'h01;
	localparam logic [15:0] COUNT_RESET   = 16'h0000;
	localparam logic [7:0]  BYTE_ZERO     = 8'h00;

	// delta-sum leak per sample, as a right shift
	localparam int SUM_LEAK_SHIFT = 2;
endpackage

// [imtr_readout.sv]
// Purpose: readout and status of the infrared motion channel and the touch channel
// Assumes: samples arrive as one-cycle strobes from sensing logic in the core_clk domain
// Notes:   status registers are rebuilt at every sample, lighting flags at every clock; host writes to them are dropped
//
// How it works
// [RULE_01] channel 1 is motion only, channel 0 optional touch, channel 2 unused
// [RULE_02] host sets channel 0 to capacitive mode, receive 0 enabled, no transmit
// [RULE_03] host sets channel 1 to infrared mode, receive 1 enabled, no transmit
// [RULE_04] host programs tuning target above tuning base for channels 0 and 1
// [RULE_05] host keeps proximity level below contact level
// [RULE_06] host keeps motion exit level at or below motion enter level
// [RULE_07] event flags bit 1 set when the infrared channel sees movement
// [RULE_08] event flags bit 0 set when the touch sensor becomes active
// [RULE_09] global activation bit 3 shows an infrared motion event occurred
// [RULE_10] global activation bits 0 and 1 give channel 0 proximity and touch
// [RULE_11] lighting bit 4 high while pwm level changes, low while constant
// [RULE_12] lighting bit 3 high while duty rises, low while it falls
// [RULE_13] raw channel 1 count readable as high and low byte
// [RULE_14] positive delta sum grows when the count rises between samples
// [RULE_15] negative delta sum grows when the count falls between samples
// [RULE_16] event raised when either sum exceeds scale times enter level
// [RULE_17] no new event until sums fall below scale times exit level
// [RULE_18] host writes to flag, count and sum registers are ignored
`timescale 1ns/1ns

module imtr_readout
	import imtr_pkg::*;
#(
	parameter int COUNT_W = 16
) (
	input  wire logic               core_clk,       // 100 MHz clock
	input  wire logic               rst,            // synchronous, active high
	input  wire logic               reg_wr_en,      // register write strobe
	input  wire logic               reg_rd_en,      // register read strobe
	input  wire logic [7:0]         reg_addr,       // register byte address
	input  wire logic [7:0]         reg_wr_data,    // write byte
	output logic      [7:0]         reg_rd_data,    // read byte, valid with reg_rd_valid
	output logic                    reg_rd_valid,   // one-cycle read answer
	input  wire logic               motion_sample,  // channel 1 sample strobe
	input  wire logic [COUNT_W-1:0] motion_count,   // channel 1 raw count
	input  wire logic               touch_sample,   // channel 0 sample strobe
	input  wire logic [7:0]         touch_depth,    // channel 0 divergence below average
	input  wire logic [7:0]         pwm_duty        // current lighting duty level
);

	////////////////////////////////////////////////////////////////////////
	// configuration registers

	logic [7:0] chan_zero_sensor_config;
	logic [7:0] chan_one_sensor_config;
	logic [7:0] global_sensor_config;
	logic [7:0] chan_zero_tuning_config;
	logic [7:0] chan_one_tuning_config;
	logic [7:0] extra_global_sensor_config;
	logic [7:0] proximity_level;
	logic [7:0] contact_level;
	logic [7:0] motion_global_config;
	logic [7:0] motion_enter_level;
	logic [7:0] motion_exit_level;
	logic [7:0] motion_level_scale;

	// only configuration offsets decode; status offsets fall through
	always_ff @(posedge core_clk) begin
		if (rst) begin
			chan_zero_sensor_config    <= CFG_RESET;
			chan_one_sensor_config     <= CFG_RESET;
			global_sensor_config       <= CFG_RESET;
			chan_zero_tuning_config    <= CFG_RESET;
			chan_one_tuning_config     <= CFG_RESET;
			extra_global_sensor_config <= CFG_RESET;
			proximity_level            <= PROX_RESET;
			contact_level              <= CONTACT_RESET;
			motion_global_config       <= CFG_RESET;
			motion_enter_level         <= ENTER_RESET;
			motion_exit_level          <= EXIT_RESET;
			motion_level_scale         <= SCALE_RESET;
		end else if (reg_wr_en) begin
			case (reg_addr)   // see [RULE_18]
				CH0_SENSOR_CFG_ADDR:    chan_zero_sensor_config    <= reg_wr_data;
				CH1_SENSOR_CFG_ADDR:    chan_one_sensor_config     <= reg_wr_data;
				GLOBAL_SENSOR_CFG_ADDR: global_sensor_config       <= reg_wr_data;
				CH0_TUNING_CFG_ADDR:    chan_zero_tuning_config    <= reg_wr_data;
				CH1_TUNING_CFG_ADDR:    chan_one_tuning_config     <= reg_wr_data;
				EXTRA_SENSOR_CFG_ADDR:  extra_global_sensor_config <= reg_wr_data;
				PROXIMITY_LEVEL_ADDR:   proximity_level            <= reg_wr_data;
				CONTACT_LEVEL_ADDR:     contact_level              <= reg_wr_data;
				MOTION_CFG_ADDR:        motion_global_config       <= reg_wr_data;
				MOTION_ENTER_ADDR:      motion_enter_level         <= reg_wr_data;
				MOTION_EXIT_ADDR:       motion_exit_level          <= reg_wr_data;
				MOTION_SCALE_ADDR:      motion_level_scale         <= reg_wr_data;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// channel 1: raw count and delta sums

	logic [COUNT_W-1:0] motion_raw_count;
	logic [COUNT_W-1:0] motion_positive_delta_sum;
	logic [COUNT_W-1:0] motion_negative_delta_sum;
	logic [COUNT_W-1:0] next_pos_sum;
	logic [COUNT_W-1:0] next_neg_sum;
	logic               first_seen;

	// leak then add, saturating; without the leak a sum could never fall to re-arm
	function automatic logic [COUNT_W-1:0] leak_add(input logic [COUNT_W-1:0] sum,
	                                                input logic [COUNT_W-1:0] delta);
		logic [COUNT_W:0] total;
		total = {1'b0, sum - (sum >> SUM_LEAK_SHIFT)} + {1'b0, delta};
		leak_add = total[COUNT_W] ? {COUNT_W{1'b1}} : total[COUNT_W-1:0];
	endfunction

	always_comb begin
		next_pos_sum = leak_add(motion_positive_delta_sum, '0);
		next_neg_sum = leak_add(motion_negative_delta_sum, '0);
		if (first_seen && motion_count > motion_raw_count) begin
			next_pos_sum = leak_add(motion_positive_delta_sum,
			                        motion_count - motion_raw_count);   // see [RULE_14]
		end else if (first_seen && motion_count < motion_raw_count) begin
			next_neg_sum = leak_add(motion_negative_delta_sum,
			                        motion_raw_count - motion_count);   // see [RULE_15]
		end
	end

	// channel 1 is the motion channel whatever channel 0 does
	always_ff @(posedge core_clk) begin
		if (rst) begin
			motion_raw_count          <= COUNT_RESET;
			motion_positive_delta_sum <= COUNT_RESET;
			motion_negative_delta_sum <= COUNT_RESET;
			first_seen                <= 1'b0;
		end else if (motion_sample) begin   // see [RULE_01]
			motion_raw_count          <= motion_count;   // see [RULE_13]
			motion_positive_delta_sum <= next_pos_sum;
			motion_negative_delta_sum <= next_neg_sum;
			first_seen                <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// motion event detection with hysteresis

	logic [15:0] enter_limit;
	logic [15:0] exit_limit;
	logic        motion_armed;
	logic        motion_trigger_flag;
	logic        infrared_event_flag;
	logic        above_enter;
	logic        below_exit;

	function automatic logic [15:0] scaled(input logic [7:0] level, input logic [7:0] scale);
		scaled = level * scale;
	endfunction

	always_comb begin
		enter_limit = scaled(motion_enter_level, motion_level_scale);
		exit_limit  = scaled(motion_exit_level, motion_level_scale);
		above_enter = (16'(next_pos_sum) > enter_limit) || (16'(next_neg_sum) > enter_limit);
		below_exit  = (16'(next_pos_sum) < exit_limit) && (16'(next_neg_sum) < exit_limit);
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			motion_armed        <= 1'b1;
			motion_trigger_flag <= 1'b0;
			infrared_event_flag <= 1'b0;
		end else if (motion_sample) begin
			motion_trigger_flag <= 1'b0;
			if (motion_armed && above_enter) begin
				motion_armed        <= 1'b0;   // see [RULE_16]
				motion_trigger_flag <= 1'b1;   // see [RULE_07]
				infrared_event_flag <= 1'b1;   // see [RULE_09]
			end else if (!motion_armed && below_exit) begin
				motion_armed        <= 1'b1;   // see [RULE_17]
				infrared_event_flag <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// channel 0: optional touch, two-level activation

	logic touch_enabled;
	logic chan_zero_near_flag;
	logic chan_zero_contact_flag;
	logic contact_event;

	assign touch_enabled = chan_zero_sensor_config[CH0_RX0_ENABLE_BIT];

	always_ff @(posedge core_clk) begin
		if (rst) begin
			chan_zero_near_flag    <= 1'b0;
			chan_zero_contact_flag <= 1'b0;
			contact_event          <= 1'b0;
		end else if (!touch_enabled) begin
			chan_zero_near_flag    <= 1'b0;
			chan_zero_contact_flag <= 1'b0;
			contact_event          <= 1'b0;
		end else if (touch_sample) begin
			chan_zero_near_flag    <= touch_depth > proximity_level;   // see [RULE_10]
			chan_zero_contact_flag <= touch_depth > contact_level;     // see [RULE_10]
			contact_event <= (touch_depth > contact_level) && !chan_zero_contact_flag;   // see [RULE_08]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// lighting activity

	logic [7:0] prev_duty;
	logic       pwm_changing_flag;
	logic       duty_rising_flag;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			// track the live level in reset so release shows no false change or rise
			prev_duty         <= pwm_duty;
			pwm_changing_flag <= 1'b0;
			duty_rising_flag  <= 1'b0;
		end else begin
			prev_duty         <= pwm_duty;
			pwm_changing_flag <= pwm_duty != prev_duty;   // see [RULE_11]
			// direction holds its last value while the level is steady
			if (pwm_duty > prev_duty) begin
				duty_rising_flag <= 1'b1;   // see [RULE_12]
			end else if (pwm_duty < prev_duty) begin
				duty_rising_flag <= 1'b0;   // see [RULE_12]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read port

	logic [7:0] event_flags;
	logic [7:0] global_activation_flags;
	logic [7:0] lighting_flags;
	logic [7:0] next_rd_data;

	always_comb begin
		event_flags = BYTE_ZERO;
		event_flags[MOTION_TRIGGER_BIT] = motion_trigger_flag;
		event_flags[CONTACT_EVENT_BIT]  = contact_event;
		global_activation_flags = BYTE_ZERO;
		global_activation_flags[INFRARED_EVENT_BIT] = infrared_event_flag;
		global_activation_flags[NEAR_FLAG_BIT]      = chan_zero_near_flag;
		global_activation_flags[CONTACT_FLAG_BIT]   = chan_zero_contact_flag;
		lighting_flags = BYTE_ZERO;
		lighting_flags[PWM_CHANGING_BIT] = pwm_changing_flag;
		lighting_flags[DUTY_RISING_BIT]  = duty_rising_flag;
	end

	always_comb begin
		case (reg_addr)
			EVENT_FLAGS_ADDR:       next_rd_data = event_flags;
			GLOBAL_ACT_ADDR:        next_rd_data = global_activation_flags;
			LIGHTING_FLAGS_ADDR:    next_rd_data = lighting_flags;
			RAW_COUNT_HI_ADDR:      next_rd_data = motion_raw_count[15:8];
			RAW_COUNT_LO_ADDR:      next_rd_data = motion_raw_count[7:0];
			POS_SUM_HI_ADDR:        next_rd_data = motion_positive_delta_sum[15:8];
			POS_SUM_LO_ADDR:        next_rd_data = motion_positive_delta_sum[7:0];
			NEG_SUM_HI_ADDR:        next_rd_data = motion_negative_delta_sum[15:8];
			NEG_SUM_LO_ADDR:        next_rd_data = motion_negative_delta_sum[7:0];
			CH0_SENSOR_CFG_ADDR:    next_rd_data = chan_zero_sensor_config;
			CH1_SENSOR_CFG_ADDR:    next_rd_data = chan_one_sensor_config;
			GLOBAL_SENSOR_CFG_ADDR: next_rd_data = global_sensor_config;
			CH0_TUNING_CFG_ADDR:    next_rd_data = chan_zero_tuning_config;
			CH1_TUNING_CFG_ADDR:    next_rd_data = chan_one_tuning_config;
			EXTRA_SENSOR_CFG_ADDR:  next_rd_data = extra_global_sensor_config;
			PROXIMITY_LEVEL_ADDR:   next_rd_data = proximity_level;
			CONTACT_LEVEL_ADDR:     next_rd_data = contact_level;
			MOTION_CFG_ADDR:        next_rd_data = motion_global_config;
			MOTION_ENTER_ADDR:      next_rd_data = motion_enter_level;
			MOTION_EXIT_ADDR:       next_rd_data = motion_exit_level;
			MOTION_SCALE_ADDR:      next_rd_data = motion_level_scale;
			default:                next_rd_data = BYTE_ZERO;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			reg_rd_data  <= BYTE_ZERO;
			reg_rd_valid <= 1'b0;
		end else begin
			reg_rd_valid <= reg_rd_en;
			if (reg_rd_en) begin
				reg_rd_data <= next_rd_data;
			end
		end
	end

endmodule

// [imtr_readout_asserts.sv]
// Purpose: concurrent checks on the readout block's register and sample ports
// Assumes: read answers come one cycle after the strobe edge
// Notes:   sees only top-level ports; bound at the foot of this file
`timescale 1ns/1ns
module imtr_readout_asserts
	import imtr_pkg::*;
#(
	parameter int COUNT_W = 16
) (
	input wire logic               core_clk,      // clock
	input wire logic               rst,           // sync reset
	input wire logic               reg_wr_en,     // write strobe
	input wire logic               reg_rd_en,     // read strobe
	input wire logic [7:0]         reg_addr,      // byte address
	input wire logic [7:0]         reg_wr_data,   // write byte
	input wire logic [7:0]         reg_rd_data,   // read byte
	input wire logic               reg_rd_valid,  // read answer
	input wire logic               motion_sample, // channel 1 strobe
	input wire logic [COUNT_W-1:0] motion_count,  // channel 1 count
	input wire logic               touch_sample,  // channel 0 strobe
	input wire logic [7:0]         touch_depth,   // channel 0 depth
	input wire logic [7:0]         pwm_duty       // duty level
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	logic [7:0] scale_shadow; // last scale written, mirrors the stored copy
	always_ff @(posedge core_clk) begin
		if (rst) begin
			scale_shadow <= SCALE_RESET;
		end else if (reg_wr_en && reg_addr == MOTION_SCALE_ADDR) begin
			scale_shadow <= reg_wr_data;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	sequence raw_hi_after_sample;
		motion_sample ##1 (!motion_sample && reg_rd_en && reg_addr == RAW_COUNT_HI_ADDR);
	endsequence
	sequence duty_rising_run;
		(pwm_duty > $past(pwm_duty))[*3];
	endsequence
	sequence duty_steady_run;
		$stable(pwm_duty)[*3];
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	a_read_answers: assert property (
		reg_rd_en ##1 !reg_rd_en |-> reg_rd_valid ##1 !reg_rd_valid)
		else $error("read strobe got no single answer");
	a_no_spurious_valid: assert property (
		reg_rd_valid |-> $past(reg_rd_en))
		else $error("read answer without a read");
	a_rd_data_holds: assert property (
		!reg_rd_valid |-> $stable(reg_rd_data))
		else $error("read byte moved between answers");
	a_unmapped_zero: assert property (
		reg_rd_en && !(reg_addr inside {8'h10, 8'h12, 8'h13, [8'h22:8'h23], [8'h34:8'h37],
		[8'h50:8'h51], [8'h53:8'h55], 8'h57, [8'h60:8'h61], [8'h90:8'h93]})
		|=> reg_rd_data == BYTE_ZERO)
		else $error("unmapped read not zero");
	a_event_bits_only: assert property (
		reg_rd_en && reg_addr == EVENT_FLAGS_ADDR |=> reg_rd_data[7:2] == 6'h00)
		else $error("stray event flag bits");
	a_global_bits_only: assert property (
		reg_rd_en && reg_addr == GLOBAL_ACT_ADDR |=> reg_rd_data[7:4] == 4'h0 && !reg_rd_data[2])
		else $error("stray activation bits");
	a_raw_hi_pairing: assert property (
		raw_hi_after_sample |=> reg_rd_data == $past(motion_count[15:8], 2))
		else $error("raw high byte wrong");
	a_lighting_steady: assert property (
		duty_steady_run ##0 (reg_rd_en && reg_addr == LIGHTING_FLAGS_ADDR)
		|=> !reg_rd_data[PWM_CHANGING_BIT])
		else $error("changing flag raised for a steady duty");
	a_lighting_rising: assert property (
		duty_rising_run ##0 (reg_rd_en && reg_addr == LIGHTING_FLAGS_ADDR)
		|=> reg_rd_data[DUTY_RISING_BIT] && reg_rd_data[PWM_CHANGING_BIT])
		else $error("rising duty not flagged");
	a_scale_readback: assert property (
		reg_rd_en && !reg_wr_en && reg_addr == MOTION_SCALE_ADDR |=> reg_rd_data == scale_shadow)
		else $error("scale readback wrong");
endmodule
bind imtr_readout imtr_readout_asserts #(.COUNT_W(COUNT_W)) u_chk (.core_clk(core_clk), .rst(rst),
	.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
	.reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .motion_sample(motion_sample),
	.motion_count(motion_count), .touch_sample(touch_sample), .touch_depth(touch_depth),
	.pwm_duty(pwm_duty));

// [imtr_host_model.sv]
// Purpose: host master driving the byte register port
// Assumes: tasks are entered just after a falling edge
// Notes:   idle address and data show the inverse, never the last value
`timescale 1ns/1ns
module imtr_host_model
	import imtr_pkg::*;
(
	input  wire logic core_clk,    // clock
	output logic      reg_wr_en,   // write strobe
	output logic      reg_rd_en,   // read strobe
	output logic [7:0] reg_addr,   // byte address
	output logic [7:0] reg_wr_data // write byte
);
	initial begin
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = 8'h00;
		reg_wr_data = 8'h00;
	end
	task automatic xfer(input logic is_wr, input logic [7:0] a, input logic [7:0] d);
		reg_wr_en = is_wr;
		reg_rd_en = !is_wr;
		reg_addr = a;
		reg_wr_data = d;
		@(negedge core_clk);
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = ~a;
		reg_wr_data = ~d;
		@(negedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		xfer(1'b0, a, ~a);
	endtask
	task automatic setup(input logic [7:0] enter, input logic [7:0] lv_exit, input logic [7:0] scale);
		wr(CH0_SENSOR_CFG_ADDR, 8'h01);
		wr(CH1_SENSOR_CFG_ADDR, 8'h02);
		wr(CH0_TUNING_CFG_ADDR, 8'h91);
		wr(CH1_TUNING_CFG_ADDR, 8'h91);
		wr(PROXIMITY_LEVEL_ADDR, PROX_RESET);
		wr(CONTACT_LEVEL_ADDR, CONTACT_RESET);
		wr(MOTION_ENTER_ADDR, enter);
		wr(MOTION_EXIT_ADDR, lv_exit);
		wr(MOTION_SCALE_ADDR, scale);
	endtask
endmodule

// [tb_top.sv]
// Purpose: self-checking bench for the motion / touch readout block
// Assumes: reads are queued with expectations and checked by a monitor
// Notes:   expected sums come from a local behavioural model
`timescale 1ns/1ns
module tb_top;
	import imtr_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        reg_wr_en;
	logic        reg_rd_en;
	logic [7:0]  reg_addr;
	logic [7:0]  reg_wr_data;
	logic [7:0]  reg_rd_data;
	logic        reg_rd_valid;
	logic        motion_sample = 1'b0;
	logic [15:0] motion_count = 16'h0000;
	logic        touch_sample = 1'b0;
	logic [7:0]  touch_depth = 8'h00;
	logic [7:0]  pwm_duty = 8'h40;
	logic [15:0] expq[$];
	int          seed = 32'h9b98;
	int          fails = 0;
	int          n_checks = 0;
	int          pos = 0, neg = 0, prv = 0, ramp = 0, thr_en = 16, thr_ex = 8;
	bit          first = 1'b1, armed = 1'b1, evt, tev, near, cont, ten;
	logic [15:0] c;
	logic [15:0] note; // monitor's own copy, so stimulus held in c is never overwritten
	logic [15:0] rst_tab [13] = '{{CH0_SENSOR_CFG_ADDR, CFG_RESET},
		{CH1_TUNING_CFG_ADDR, CFG_RESET}, {EXTRA_SENSOR_CFG_ADDR, CFG_RESET},
		{PROXIMITY_LEVEL_ADDR, PROX_RESET}, {CONTACT_LEVEL_ADDR, CONTACT_RESET},
		{MOTION_ENTER_ADDR, ENTER_RESET}, {MOTION_EXIT_ADDR, EXIT_RESET},
		{MOTION_SCALE_ADDR, SCALE_RESET}, 16'hff00, {EVENT_FLAGS_ADDR, BYTE_ZERO},
		{GLOBAL_ACT_ADDR, BYTE_ZERO}, {RAW_COUNT_HI_ADDR, BYTE_ZERO},
		{LIGHTING_FLAGS_ADDR, BYTE_ZERO}};
	logic [7:0]  ro_tab [5] = '{8'h10, 8'h12, 8'h22, 8'h35, 8'h36};
	logic [7:0]  rw_tab [3] = '{8'h53, 8'h57, 8'h90};
	always #5 core_clk = ~core_clk;
	imtr_host_model host (.core_clk(core_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
		.reg_addr(reg_addr), .reg_wr_data(reg_wr_data));
	imtr_readout #(.COUNT_W(16)) DUT (.core_clk(core_clk), .rst(rst), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
		.reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .motion_sample(motion_sample),
		.motion_count(motion_count), .touch_sample(touch_sample), .touch_depth(touch_depth),
		.pwm_duty(pwm_duty));
	////////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] a, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("Error register %h expected %h seen %h", a, e, g);
		end
	endtask
	always @(negedge core_clk) begin
		if (reg_rd_valid === 1'b1 && expq.size() == 0) begin
			fails++;
			$display("Error read answer expected none seen %h", reg_rd_data);
		end else if (reg_rd_valid === 1'b1) begin
			note = expq.pop_front();
			chk8(note[15:8], note[7:0], reg_rd_data);
		end
	end
	always @(negedge core_clk) pwm_duty <= pwm_duty + 8'(ramp);
	task automatic expect_rd(input logic [7:0] a, input logic [7:0] e);
		expq.push_back({a, e});
		host.rd(a);
		if (expq.size() != 0) begin
			fails++;
			$display("Error register %h expected answer seen none", a);
			summarize();
		end
	endtask
	task automatic check_all();
		expect_rd(RAW_COUNT_HI_ADDR, prv[15:8]);
		expect_rd(RAW_COUNT_LO_ADDR, prv[7:0]);
		expect_rd(POS_SUM_HI_ADDR, pos[15:8]);
		expect_rd(POS_SUM_LO_ADDR, pos[7:0]);
		expect_rd(NEG_SUM_HI_ADDR, neg[15:8]);
		expect_rd(NEG_SUM_LO_ADDR, neg[7:0]);
		expect_rd(EVENT_FLAGS_ADDR, {6'h00, evt, tev});
		expect_rd(GLOBAL_ACT_ADDR, {4'h0, !armed, 1'b0, cont, near});
	endtask
	task automatic msample(input logic [15:0] cnt);
		int d;
		d = first ? 0 : int'(cnt) - prv;
		first = 1'b0;
		pos = pos - (pos >> 2) + (d > 0 ? d : 0);
		neg = neg - (neg >> 2) + (d < 0 ? -d : 0);
		pos = (pos > 32'h0000_ffff) ? 32'h0000_ffff : pos; // sums saturate, never wrap
		neg = (neg > 32'h0000_ffff) ? 32'h0000_ffff : neg;
		if (!armed && pos < thr_ex && neg < thr_ex) armed = 1'b1;
		evt = armed && (pos > thr_en || neg > thr_en);
		if (evt) armed = 1'b0;
		prv = cnt;
		motion_sample = 1'b1;
		motion_count = cnt;
		@(negedge core_clk);
		motion_sample = 1'b0;
		motion_count = 16'($random(seed));
		check_all();
	endtask
	task automatic tsample(input logic [7:0] d);
		tev = ten && d > CONTACT_RESET && !cont;
		cont = ten && d > CONTACT_RESET;
		near = ten && d > PROX_RESET;
		touch_sample = 1'b1;
		touch_depth = d;
		@(negedge core_clk);
		touch_sample = 1'b0;
		touch_depth = ~d;
		check_all();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (60000) @(posedge core_clk);
		fails++;
		$display("Error run time expected finish seen hang");
		summarize();
	end
	initial begin
		repeat (8) @(negedge core_clk);
		rst = 1'b0;
		foreach (rst_tab[i]) expect_rd(rst_tab[i][15:8], rst_tab[i][7:0]);
		$display("reset values done");
		tsample(8'h32);
		foreach (ro_tab[i]) host.wr(ro_tab[i], 8'($random(seed)));
		check_all();
		foreach (rw_tab[i]) begin
			c = 16'($random(seed));
			host.wr(rw_tab[i], c[7:0]);
			expect_rd(rw_tab[i], c[7:0]);
		end
		$display("access kinds done");
		host.setup(8'h03, 8'h02, 8'h02);
		expect_rd(MOTION_SCALE_ADDR, 8'h02);
		ten = 1'b1;
		thr_en = 6;
		thr_ex = 4;
		foreach (rw_tab[i]) tsample(8'h05 + 8'(i * 7) + (i == 2 ? 8'h07 : 8'h00));
		tsample(8'h14);
		tsample(8'h03);
		$display("touch done");
		for (int i = 0; i < 24; i++) begin
			if (i < 16) c = 16'h03e8 + 16'($random(seed) % 12);
			msample(c);
		end
		msample(16'hffff);
		msample(16'h0000);
		msample(16'hffff);
		$display("motion done");
		ramp = 1;
		repeat (4) @(negedge core_clk);
		expect_rd(LIGHTING_FLAGS_ADDR, 8'h18);
		ramp = -1;
		repeat (4) @(negedge core_clk);
		expect_rd(LIGHTING_FLAGS_ADDR, 8'h10);
		ramp = 0;
		repeat (4) @(negedge core_clk);
		expect_rd(LIGHTING_FLAGS_ADDR, 8'h00);
		$display("lighting done");
		summarize();
	end
endmodule
